/* src/imsd_top.sv */
// apb register file, byte fifos, status flags and counters of the two-wire master data path
`timescale 1ns/1ps
`include "imsd_defs.svh"

module imsd_top import imsd_pkg::*; (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic eng_start,
	input wire logic eng_addr_nack,
	input wire logic eng_addr_write_sent,
	input wire imsd_byte_type eng_rx,
	input wire logic eng_tx_pop,
	output imsd_byte_type eng_tx,
	output imsd_target_type eng_target,
	output logic [8:0] eng_read_count
);
	logic apb_setup;
	logic apb_acc;
	logic apb_wr;
	logic apb_rd;
	logic addr_hit;
	logic [31:0] rdata_next;
	logic [31:0] prdata_reg;

	logic [7:0] tx_mem [0:1];
	logic tx_wp_reg;
	logic tx_rp_reg;
	logic [1:0] tx_cnt_reg;
	logic tx_push;
	logic tx_pop;
	logic [1:0] tx_level;

	logic [7:0] rx_mem [0:1];
	logic rx_wp_reg;
	logic rx_rp_reg;
	logic [1:0] rx_cnt_reg;
	logic rx_push;
	logic rx_pop;
	logic [7:0] rx_head;

	logic [8:0] read_count_reg;
	logic [7:0] bytes_recv_reg;
	logic [7:0] target_addr_reg;
	imsd_target_type eng_target_reg;
	imsd_byte_type eng_tx_reg;

	logic nack_flag_reg;
	logic rx_request_flag;
	logic tx_request_flag;
	logic tx_req_prev_reg;
	logic [15:0] status_word;

	logic [2:0] irq_stat_reg;
	logic [2:0] irq_stat_next;
	logic [2:0] irq_mask_reg;
	logic [2:0] irq_events;
	logic irq_reg;

	assign apb_setup = psel && !penable;
	assign apb_acc = psel && penable;
	assign apb_wr = apb_acc && pwrite;
	assign apb_rd = apb_acc && !pwrite;
	// zero wait states: every access ends in its first access cycle
	assign pready = apb_acc;

	always_comb begin
		addr_hit = 1'b1;
		case (paddr)
			`IMSD_ADDR_STATUS, `IMSD_ADDR_RX, `IMSD_ADDR_TX, `IMSD_ADDR_RCNT,
			`IMSD_ADDR_BCNT, `IMSD_ADDR_TADR, `IMSD_ADDR_IRQ_STAT,
			`IMSD_ADDR_IRQ_MASK: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end
	assign pslverr = apb_acc && !addr_hit;

	// tx register reads as zero since it is write-only
	always_comb begin
		rdata_next = `IMSD_RDATA_ZERO;
		case (paddr)
			`IMSD_ADDR_STATUS: rdata_next = {16'h0000, status_word};
			`IMSD_ADDR_RX: rdata_next = {24'h000000, rx_head};
			`IMSD_ADDR_RCNT: rdata_next = {23'h0, read_count_reg};
			`IMSD_ADDR_BCNT: rdata_next = {24'h000000, bytes_recv_reg};
			`IMSD_ADDR_TADR: rdata_next = {24'h000000, target_addr_reg};
			`IMSD_ADDR_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
			`IMSD_ADDR_IRQ_MASK: rdata_next = {29'h0, irq_mask_reg};
			default: rdata_next = `IMSD_RDATA_ZERO;
		endcase
	end

	// captured in the setup cycle so prdata is a flop; status is one cycle old
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prdata_reg <= `IMSD_RDATA_ZERO;
		end else if (apb_setup && !pwrite) begin
			prdata_reg <= rdata_next;
		end
	end
	assign prdata = prdata_reg;

	// transmit fifo, two bytes deep
	assign tx_push = apb_wr && paddr == `IMSD_ADDR_TX && tx_cnt_reg != `IMSD_FIFO_DEPTH;
	assign tx_pop = eng_tx_pop && tx_cnt_reg != 2'h0;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_mem[0] <= `IMSD_RST_BYTE;
			tx_mem[1] <= `IMSD_RST_BYTE;
			tx_wp_reg <= 1'b0;
		end else if (tx_push) begin
			tx_mem[tx_wp_reg] <= pwdata[7:0];
			tx_wp_reg <= !tx_wp_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_rp_reg <= 1'b0;
			tx_cnt_reg <= 2'h0;
		end else begin
			if (tx_pop) begin
				tx_rp_reg <= !tx_rp_reg;
			end
			tx_cnt_reg <= tx_cnt_reg + {1'b0, tx_push} - {1'b0, tx_pop};
		end
	end

	// engine sees the head byte registered
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			eng_tx_reg <= '0;
		end else begin
			eng_tx_reg.valid <= (tx_cnt_reg + {1'b0, tx_push} - {1'b0, tx_pop}) != 2'h0;
			eng_tx_reg.data <= (tx_cnt_reg == 2'h0 || (tx_pop && tx_cnt_reg == 2'h1)) ?
				pwdata[7:0] : tx_mem[tx_pop ? !tx_rp_reg : tx_rp_reg];
		end
	end
	assign eng_tx = eng_tx_reg;

	// the 10 code is never produced; a single byte always reads as 01
	always_comb begin
		case (tx_cnt_reg)
			2'h0: tx_level = `IMSD_LVL_EMPTY;
			2'h1: tx_level = `IMSD_LVL_ONE;
			default: tx_level = `IMSD_LVL_FULL;
		endcase
	end

	// receive fifo; a byte arriving while full is dropped
	assign rx_push = eng_rx.valid && rx_cnt_reg != `IMSD_FIFO_DEPTH;
	assign rx_pop = apb_rd && paddr == `IMSD_ADDR_RX && rx_cnt_reg != 2'h0;
	assign rx_head = rx_cnt_reg == 2'h0 ? `IMSD_RST_BYTE : rx_mem[rx_rp_reg];

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rx_mem[0] <= `IMSD_RST_BYTE;
			rx_mem[1] <= `IMSD_RST_BYTE;
			rx_wp_reg <= 1'b0;
		end else if (rx_push) begin
			rx_mem[rx_wp_reg] <= eng_rx.data;
			rx_wp_reg <= !rx_wp_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rx_rp_reg <= 1'b0;
			rx_cnt_reg <= 2'h0;
		end else begin
			if (rx_pop) begin
				rx_rp_reg <= !rx_rp_reg;
			end
			rx_cnt_reg <= rx_cnt_reg + {1'b0, rx_push} - {1'b0, rx_pop};
		end
	end

	// read count and address are held as written; the engine interprets them
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			read_count_reg <= `IMSD_RST_RCNT;
			target_addr_reg <= `IMSD_RST_BYTE;
		end else if (apb_wr) begin
			if (paddr == `IMSD_ADDR_RCNT) begin
				read_count_reg <= pwdata[`IMSD_RCNT_W-1:0];
			end
			if (paddr == `IMSD_ADDR_TADR) begin
				target_addr_reg <= pwdata[7:0];
			end
		end
	end
	assign eng_read_count = read_count_reg;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			eng_target_reg <= '0;
		end else if (eng_start) begin
			eng_target_reg.addr <= target_addr_reg[7:1];
			eng_target_reg.read <= target_addr_reg[`IMSD_ADR_DIR];
		end
	end
	assign eng_target = eng_target_reg;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bytes_recv_reg <= `IMSD_RST_BYTE;
		end else if (eng_start) begin
			bytes_recv_reg <= `IMSD_RST_BYTE;
		end else if (rx_push) begin
			bytes_recv_reg <= bytes_recv_reg + 8'h01;
		end
	end

	// status flags
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			nack_flag_reg <= 1'b0;
		end else if (eng_addr_nack) begin
			nack_flag_reg <= 1'b1;
		end else if (eng_start) begin
			nack_flag_reg <= 1'b0;
		end
	end
	assign rx_request_flag = rx_cnt_reg != 2'h0;
	assign tx_request_flag = eng_addr_write_sent && tx_cnt_reg != `IMSD_FIFO_DEPTH;

	always_comb begin
		status_word = 16'h0000;
		status_word[`IMSD_ST_NACK] = nack_flag_reg;
		status_word[`IMSD_ST_RXQ] = rx_request_flag;
		status_word[`IMSD_ST_TXQ] = tx_request_flag;
		status_word[1:0] = tx_level;
	end

	// interrupts: sticky events, write one to clear, set beats clear
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_req_prev_reg <= 1'b0;
		end else begin
			tx_req_prev_reg <= tx_request_flag;
		end
	end

	always_comb begin
		irq_events = `IMSD_RST_IRQ;
		irq_events[`IMSD_IRQ_NACK] = eng_addr_nack;
		irq_events[`IMSD_IRQ_RX] = rx_push;
		irq_events[`IMSD_IRQ_TX] = tx_request_flag && !tx_req_prev_reg;
		irq_stat_next = irq_stat_reg | irq_events;
		if (apb_wr && paddr == `IMSD_ADDR_IRQ_STAT) begin
			irq_stat_next = (irq_stat_reg & ~pwdata[`IMSD_IRQ_W-1:0]) | irq_events;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_stat_reg <= `IMSD_RST_IRQ;
			irq_mask_reg <= `IMSD_RST_IRQ;
			irq_reg <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			if (apb_wr && paddr == `IMSD_ADDR_IRQ_MASK) begin
				irq_mask_reg <= pwdata[`IMSD_IRQ_W-1:0];
			end
			irq_reg <= |(irq_stat_next & (apb_wr && paddr == `IMSD_ADDR_IRQ_MASK ?
				pwdata[`IMSD_IRQ_W-1:0] : irq_mask_reg));
		end
	end
	assign irq = irq_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_nack_sets_flag: assert property (eng_addr_nack |=> nack_flag_reg)
		else $error("nack flag not set after address nack");
	a_nack_clears_start: assert property (eng_start && !eng_addr_nack |=> !nack_flag_reg)
		else $error("nack flag not cleared at start");
	a_rx_request_flag: assert property (eng_rx.valid && rx_cnt_reg == 2'h0
		|=> status_word[`IMSD_ST_RXQ])
		else $error("rx request not raised by incoming byte");
	a_tx_request_full: assert property (tx_cnt_reg == `IMSD_FIFO_DEPTH
		|-> !tx_request_flag)
		else $error("tx request high with full fifo");
	a_tx_level_code: assert property (tx_level != 2'h2
		&& (tx_cnt_reg == 2'h0) == (tx_level == `IMSD_LVL_EMPTY))
		else $error("tx fifo level code wrong");
	a_rx_pop_order: assert property (rx_pop && rx_cnt_reg == `IMSD_FIFO_DEPTH
		|=> rx_head == $past(rx_mem[!rx_rp_reg]))
		else $error("rx fifo head not advanced by read");
	a_byte_count_step: assert property (rx_push && !eng_start
		|=> bytes_recv_reg == $past(bytes_recv_reg) + 8'h01)
		else $error("received byte counter did not step");
	a_target_latch: assert property (eng_start
		|=> eng_target == {$past(target_addr_reg[7:1]), $past(target_addr_reg[0])})
		else $error("target address not latched at start");
	a_tx_push_valid: assert property (tx_push |=> eng_tx.valid)
		else $error("tx byte not presented after write");
	// a mask cleared in the same cycle legitimately keeps irq low
	a_irq_sticky_set: assert property (eng_addr_nack && irq_mask_reg[`IMSD_IRQ_NACK]
		&& !(apb_wr && paddr == `IMSD_ADDR_IRQ_MASK) |=> irq)
		else $error("unmasked nack did not raise irq");

	c_nack_irq: cover property (eng_addr_nack ##1 irq);
	c_rx_pop_read: cover property (rx_push ##[1:20] rx_pop);
	c_tx_full: cover property (tx_cnt_reg == `IMSD_FIFO_DEPTH ##[1:20] tx_pop);
	c_tx_request: cover property (eng_addr_write_sent && tx_request_flag ##1 irq);
endmodule

/* src/imsd_defs.svh */
// register map, field positions and reset values of the master status and data block
`ifndef IMSD_DEFS_SVH
`define IMSD_DEFS_SVH

`define IMSD_ADDR_STATUS 32'hffff0804
`define IMSD_ADDR_RX 32'hffff0808
`define IMSD_ADDR_TX 32'hffff080c
`define IMSD_ADDR_RCNT 32'hffff0810
`define IMSD_ADDR_BCNT 32'hffff0814
`define IMSD_ADDR_TADR 32'hffff0818
`define IMSD_ADDR_IRQ_STAT 32'hffff0840
`define IMSD_ADDR_IRQ_MASK 32'hffff0844

`define IMSD_ST_NACK 4
`define IMSD_ST_RXQ 3
`define IMSD_ST_TXQ 2
`define IMSD_IRQ_NACK 0
`define IMSD_IRQ_RX 1
`define IMSD_IRQ_TX 2
`define IMSD_IRQ_W 3

`define IMSD_LVL_EMPTY 2'h0
`define IMSD_LVL_ONE 2'h1
`define IMSD_LVL_FULL 2'h3

`define IMSD_FIFO_DEPTH 2'h2
`define IMSD_RCNT_W 9
`define IMSD_RCNT_EXT 8
`define IMSD_ADR_DIR 0

`define IMSD_RST_BYTE 8'h00
`define IMSD_RST_RCNT 9'h000
`define IMSD_RST_IRQ 3'h0
`define IMSD_RDATA_ZERO 32'h00000000

`endif

/* src/imsd_pkg.sv */
// types shared by the master status and data block
package imsd_pkg;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} imsd_byte_type;

	typedef struct packed {
		logic [6:0] addr;
		logic read;
	} imsd_target_type;
endpackage

/* bench/imsd_engine_model.sv */
// behavioural master engine feeding address outcomes, received bytes and pops to the block
`timescale 1ns/1ps
module imsd_engine_model import imsd_pkg::*; (
	input wire logic ref_clk,
	output logic eng_start,
	output logic eng_addr_nack,
	output logic eng_addr_write_sent,
	output imsd_byte_type eng_rx,
	output logic eng_tx_pop
);
	initial begin
		eng_start = 1'b0;
		eng_addr_nack = 1'b0;
		eng_addr_write_sent = 1'b0;
		eng_tx_pop = 1'b0;
		eng_rx = '0;
	end
	// each strobe is followed by a quiet edge so back to back calls never collide
	task start;
		eng_start <= 1'b1;
		@(posedge ref_clk);
		eng_start <= 1'b0;
		@(posedge ref_clk);
	endtask
	task nack;
		eng_addr_nack <= 1'b1;
		@(posedge ref_clk);
		eng_addr_nack <= 1'b0;
		@(posedge ref_clk);
	endtask
	task pop;
		eng_tx_pop <= 1'b1;
		@(posedge ref_clk);
		eng_tx_pop <= 1'b0;
		@(posedge ref_clk);
	endtask
	task write_sent(input logic v);
		eng_addr_write_sent <= v;
		@(posedge ref_clk);
	endtask
	// released data shows the inverse so a stale byte is never taken twice
	task give_byte(input logic [7:0] d);
		eng_rx <= {1'b1, d};
		@(posedge ref_clk);
		eng_rx <= {1'b0, ~d};
		@(posedge ref_clk);
	endtask
endmodule

/* bench/i2c_master_status_data_count_bench.sv */
// self-checking bench of the master status and data block
`timescale 1ns/1ps
`include "imsd_defs.svh"
module i2c_master_status_data_count_bench import imsd_pkg::*; ();
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, a;
	logic pready, pslverr, irq, err;
	logic eng_start, eng_addr_nack, eng_addr_write_sent, eng_tx_pop;
	imsd_byte_type eng_rx, eng_tx;
	imsd_target_type eng_target;
	logic [8:0] eng_read_count;
	logic [7:0] rxq[$];
	logic [7:0] txq[$];
	logic [31:0] adr[8] = '{`IMSD_ADDR_STATUS, `IMSD_ADDR_RX, `IMSD_ADDR_TX, `IMSD_ADDR_RCNT,
		`IMSD_ADDR_BCNT, `IMSD_ADDR_TADR, `IMSD_ADDR_IRQ_STAT, `IMSD_ADDR_IRQ_MASK};
	int miscompares = 0;
	int num_checks = 0;
	int bcnt = 0;
	int i;
	always #2.5 ref_clk = ~ref_clk;
	imsd_top dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .eng_start(eng_start), .eng_addr_nack(eng_addr_nack),
		.eng_addr_write_sent(eng_addr_write_sent), .eng_rx(eng_rx), .eng_tx_pop(eng_tx_pop),
		.eng_tx(eng_tx), .eng_target(eng_target), .eng_read_count(eng_read_count));
	imsd_engine_model eng (.ref_clk(ref_clk), .eng_start(eng_start),
		.eng_addr_nack(eng_addr_nack), .eng_addr_write_sent(eng_addr_write_sent),
		.eng_rx(eng_rx), .eng_tx_pop(eng_tx_pop));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// request held until pready is seen high, then released with one idle edge
	task apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			print_verdict;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task rc(input string n, input logic [31:0] ad, input logic [31:0] e);
		apb(1'b0, ad, 32'h0);
		chk(n, rd, e);
	endtask
	// status reads show the value of the setup cycle, so let events settle first
	task idle;
		repeat (2) @(posedge ref_clk);
	endtask
	initial begin
		void'($urandom(85536));
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		for (i = 0; i < 8; i++) rc("reset value", adr[i], 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		$display("test reset done");
		for (i = 0; i < 2; i++) begin
			a = i ? 32'hf5 : $urandom;
			apb(1'b1, `IMSD_ADDR_TADR, a);
			rc("target", `IMSD_ADDR_TADR, a & 32'hff);
			eng.start;
			chk("eng_target", {24'h0, eng_target}, a & 32'hff);
		end
		a = $urandom;
		apb(1'b1, `IMSD_ADDR_RCNT, a);
		rc("read_count", `IMSD_ADDR_RCNT, a & 32'h1ff);
		chk("eng_read_count", {23'h0, eng_read_count}, a & 32'h1ff);
		$display("test address done");
		apb(1'b1, `IMSD_ADDR_IRQ_MASK, 32'h7);
		for (i = 0; i < 3; i++) begin
			a = $urandom;
			eng.give_byte(a[7:0]);
			if (rxq.size() < 2) begin
				rxq.push_back(a[7:0]);
				bcnt++;
			end
		end
		idle;
		rc("status", `IMSD_ADDR_STATUS, 32'h8);
		rc("bytes_received", `IMSD_ADDR_BCNT, bcnt);
		chk("irq", {31'h0, irq}, 32'h1);
		while (rxq.size() > 0) rc("rx", `IMSD_ADDR_RX, rxq.pop_front());
		idle;
		rc("status", `IMSD_ADDR_STATUS, 32'h0);
		apb(1'b1, `IMSD_ADDR_IRQ_STAT, 32'h7);
		idle;
		chk("irq", {31'h0, irq}, 32'h0);
		$display("test receive done");
		for (i = 0; i < 3; i++) begin
			a = $urandom;
			apb(1'b1, `IMSD_ADDR_TX, a);
			if (txq.size() < 2) txq.push_back(a[7:0]);
		end
		idle;
		rc("status", `IMSD_ADDR_STATUS, 32'h3);
		rc("tx", `IMSD_ADDR_TX, 32'h0);
		chk("eng_tx", {23'h0, eng_tx}, {23'h0, 1'b1, txq[0]});
		eng.pop;
		void'(txq.pop_front());
		idle;
		rc("status", `IMSD_ADDR_STATUS, 32'h1);
		chk("eng_tx", {23'h0, eng_tx}, {23'h0, 1'b1, txq[0]});
		eng.write_sent(1'b1);
		idle;
		rc("status", `IMSD_ADDR_STATUS, 32'h5);
		chk("irq", {31'h0, irq}, 32'h1);
		eng.pop;
		idle;
		rc("status", `IMSD_ADDR_STATUS, 32'h4);
		$display("test transmit done");
		apb(1'b1, `IMSD_ADDR_IRQ_MASK, 32'h0);
		apb(1'b1, `IMSD_ADDR_IRQ_STAT, 32'h7);
		eng.nack;
		idle;
		rc("status", `IMSD_ADDR_STATUS, 32'h14);
		rc("irq_status", `IMSD_ADDR_IRQ_STAT, 32'h1);
		chk("irq", {31'h0, irq}, 32'h0);
		eng.start;
		idle;
		rc("status", `IMSD_ADDR_STATUS, 32'h4);
		// nack with its enable set must reach the interrupt line
		apb(1'b1, `IMSD_ADDR_IRQ_STAT, 32'h7);
		apb(1'b1, `IMSD_ADDR_IRQ_MASK, 32'h1);
		chk("irq", {31'h0, irq}, 32'h0);
		eng.nack;
		chk("irq", {31'h0, irq}, 32'h1);
		apb(1'b1, 32'hffff0800, $urandom);
		chk("slverr", {31'h0, err}, 32'h1);
		rc("unmapped", 32'hffff0800, 32'h0);
		$display("test nack done");
		print_verdict;
	end
endmodule
